// *** gated_pulse_counter.sv ***
// Chosen here: the register offsets and register access over APB.
`timescale 1ns/1ps
module gated_pulse_counter
    import gpc_pkg::*;
#(
    parameter int HALF_PERIOD_CYC = gpc_pkg::HALF_CYC
)
(
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // Pins
    input  wire logic        pulseInput,
    input  wire logic        hardResetInput,
    input  wire logic        gateInput,
    // Interrupt
    output logic             irq
);

    logic [CTRL_W-1:0]  ctrl_q;
    logic [DEST_W-1:0]  dest_q;
    logic [ST_W-1:0]    status_q;
    logic [ST_W-1:0]    status_d;
    logic [ST_W-1:0]    mask_q;
    logic [FILT_W-1:0]  filter_q;
    logic [FILT_W-1:0]  filterEff;
    logic [COUNT_W-1:0] count_q;
    logic [PIN_N-1:0]   rawPins;
    logic [PIN_N-1:0]   filt;
    logic               countedSig;
    logic               countedDly_q;
    logic               gateDly_q;
    logic               countEdge;
    logic               gateFall;
    logic               hardRstActive;
    logic               clearReq;
    logic               countEn;
    logic               wrap;
    logic               xferGo;
    logic               destOk;
    logic               xferWr;
    logic               setupPh;
    logic               wrEn;
    logic               dataWr;
    logic [DEST_W-1:0]  busIdx;
    logic [COUNT_W-1:0] rdData;
    logic [ST_W-1:0]    w1c;

    localparam logic [FILT_W-1:0] FILT_LIMIT = FILT_W'(HALF_PERIOD_CYC / 2);

    function automatic logic isData(input logic [11:0] a);
        isData = (a >= OFF_DATA) && (a < OFF_DATA + 12'(4 * DATA_DEPTH));
    endfunction

    function automatic logic addrHit(input logic [11:0] a);
        if (a[1:0] != 2'h0)
            addrHit = 1'b0;
        else if (a == OFF_CTRL || a == OFF_DEST || a == OFF_COUNT)
            addrHit = 1'b1;
        else if (a == OFF_STATUS || a == OFF_MASK)
            addrHit = 1'b1;
        else if (a == OFF_INPUTS || a == OFF_FILTER)
            addrHit = 1'b1;
        else
            addrHit = isData(a);
    endfunction

    // filter clamp
    // A filter longer than half the fastest pulse period would swallow pulses
    assign filterEff = (filter_q > FILT_LIMIT) ? FILT_LIMIT : filter_q;

    assign rawPins = {gateInput, hardResetInput, pulseInput};

    genvar g;
    generate
        for (g = 0; g < PIN_N; g++)
        begin : gen_pin
            input_filter #(
                .W (FILT_W)
            ) u_filt (
                .clk_sys   (clk_sys),
                .nrst      (nrst),
                .pinIn     (rawPins[g]),
                .filterLen (filterEff),
                .levelOut  (filt[g])
            );
        end
    endgenerate

    assign countedSig = filt[PIN_PULSE] & filt[PIN_GATE];
    assign countEdge  = countedSig & ~countedDly_q;
    assign gateFall   = ~filt[PIN_GATE] & gateDly_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            countedDly_q <= 1'b0;
            gateDly_q    <= 1'b0;
        end
        else
        begin
            countedDly_q <= countedSig;
            gateDly_q    <= filt[PIN_GATE];
        end
    end

    assign hardRstActive = ctrl_q[CTRL_HRST_EN] & filt[PIN_HRST];
    assign clearReq = hardRstActive | ctrl_q[CTRL_SOFT_RST];
    assign countEn = ctrl_q[CTRL_RUN] & countEdge & ~hardRstActive;
    assign wrap = countEn & ~clearReq & (count_q == COUNT_MAX);

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            count_q <= '0;
        end
        else if (clearReq)
        begin
            count_q <= '0;
        end
        else if (countEn)
        begin
            count_q <= count_q + 1'b1;
        end
    end

    assign xferGo = gateFall & ctrl_q[CTRL_RUN];
    assign destOk = ctrl_q[CTRL_FAST] ? (int'(dest_q) < FAST_DEPTH)
                                      : (int'(dest_q) < DATA_DEPTH);
    assign xferWr = xferGo & destOk;

    // APB: zero-wait slave
    assign setupPh = psel & ~penable;
    assign wrEn    = psel & penable & pwrite & addrHit(paddr);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~addrHit(paddr);
    assign dataWr  = wrEn & isData(paddr);
    assign busIdx  = DEST_W'((paddr - OFF_DATA) >> 2);

    data_reg_file #(
        .DEPTH (DATA_DEPTH),
        .W     (COUNT_W),
        .AW    (DEST_W)
    ) u_data (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .swWr     (dataWr),
        .swIdx    (busIdx),
        .swData   (pwdata[COUNT_W-1:0]),
        .xferWr   (xferWr),
        .xferIdx  (dest_q),
        .xferData (count_q),
        .rdIdx    (busIdx),
        .rdData   (rdData)
    );

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            ctrl_q   <= CTRL_RESET;
            dest_q   <= DEST_RESET;
            mask_q   <= '0;
            filter_q <= FILT_RESET;
        end
        else if (wrEn)
        begin
            if (paddr == OFF_CTRL)
                ctrl_q <= pwdata[CTRL_W-1:0];
            else if (paddr == OFF_DEST)
                dest_q <= pwdata[DEST_W-1:0];
            else if (paddr == OFF_MASK)
                mask_q <= pwdata[ST_W-1:0];
            else if (paddr == OFF_FILTER)
                filter_q <= pwdata[FILT_W-1:0];
        end
    end

    // Sticky status: set wins over write-one-to-clear
    always_comb
    begin
        w1c = (wrEn && paddr == OFF_STATUS) ? pwdata[ST_W-1:0] : '0;
        status_d = status_q & ~w1c;
        if (clearReq)
            status_d[ST_OVF] = 1'b0;
        if (wrap)
            status_d[ST_OVF] = 1'b1;
        if (xferWr)
            status_d[ST_XFER] = 1'b1;
        if (xferGo && !destOk)
            status_d[ST_DSTERR] = 1'b1;
    end

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
            status_q <= '0;
        else
            status_q <= status_d;
    end

    assign irq = |(status_q & mask_q);

    // Read data captured in setup so it is stable through the access phase
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            prdata <= '0;
        end
        else if (setupPh)
        begin
            if (paddr == OFF_CTRL)
                prdata <= 32'(ctrl_q);
            else if (paddr == OFF_DEST)
                prdata <= 32'(dest_q);
            else if (paddr == OFF_COUNT)
                prdata <= 32'(count_q);
            else if (paddr == OFF_STATUS)
                prdata <= 32'(status_q);
            else if (paddr == OFF_MASK)
                prdata <= 32'(mask_q);
            else if (paddr == OFF_INPUTS)
                prdata <= 32'(filt);
            else if (paddr == OFF_FILTER)
                prdata <= 32'(filter_q);
            // Unaligned data addresses fall through and read zero
            else if (addrHit(paddr))
                prdata <= 32'(rdData);
            else
                prdata <= 32'h0000_0000;
        end
    end

    chk_gate_off_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!filt[PIN_GATE] && !clearReq) |=> (count_q == $past(count_q)))
        else $error("count moved with gate off");

    chk_gate_fall_store: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (ctrl_q[CTRL_RUN] && $fell(filt[PIN_GATE]) && destOk)
        |=> status_q[ST_XFER])
        else $error("gate fall did not store count");

    chk_wrap_overflow: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (countEn && !clearReq && count_q == 16'hFFFF)
        |=> (count_q == 16'h0000) && status_q[ST_OVF])
        else $error("wrap at 65535 wrong");

    chk_powerup_zero: assert property (
        @(posedge clk_sys)
        $rose(nrst) |-> (count_q == 16'h0000))
        else $error("count not zero after power-up");

    chk_stop_hold: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!ctrl_q[CTRL_RUN] && !clearReq) |=> $stable(count_q))
        else $error("count moved while stopped");

    chk_hard_clear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        hardRstActive |=> (count_q == 16'h0000))
        else $error("hard reset did not clear");

    chk_plain_step: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!ctrl_q[CTRL_HRST_EN] && !ctrl_q[CTRL_SOFT_RST] && countEn)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("count did not step with hard reset off");

    chk_soft_clear: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ctrl_q[CTRL_SOFT_RST][*2] |-> (count_q == 16'h0000))
        else $error("soft reset did not hold zero");

    chk_gate_resume: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ($rose(filt[PIN_GATE]) && !clearReq && count_q != 16'h0000 && count_q != 16'hFFFF)
        |=> (count_q != 16'h0000))
        else $error("gate reassert cleared count");

    chk_gate_pulse: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ($rose(filt[PIN_GATE]) && filt[PIN_PULSE] && ctrl_q[CTRL_RUN]
         && !clearReq && count_q != 16'hFFFF)
        |=> (count_q == $past(count_q) + 16'h0001))
        else $error("gate toggle not counted");

    chk_filter_limit: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (filterEff <= FILT_LIMIT))
        else $error("filter exceeds pulse half period");

    chk_fast_dest: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (xferGo && ctrl_q[CTRL_FAST] && dest_q >= 7'h20)
        |=> status_q[ST_DSTERR])
        else $error("fast mode destination not refused");

    chk_reset_priority: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (clearReq && countEdge)
        |=> (count_q == 16'h0000) && !status_q[ST_OVF])
        else $error("pulse beat reset");

endmodule

// *** gpc_pkg.sv ***
package gpc_pkg;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL   = 12'h000;
    localparam logic [11:0] OFF_DEST   = 12'h004;
    localparam logic [11:0] OFF_COUNT  = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_MASK   = 12'h010;
    localparam logic [11:0] OFF_INPUTS = 12'h014;
    localparam logic [11:0] OFF_FILTER = 12'h018;
    localparam logic [11:0] OFF_DATA   = 12'h100;

    // Control fields
    localparam int CTRL_RUN      = 0;
    localparam int CTRL_HRST_EN  = 1;
    localparam int CTRL_SOFT_RST = 2;
    localparam int CTRL_FAST     = 3;
    localparam int CTRL_W        = 4;
    localparam logic [3:0] CTRL_RESET = 4'h0;

    // Status and mask fields
    localparam int ST_OVF    = 0;
    localparam int ST_XFER   = 1;
    localparam int ST_DSTERR = 2;
    localparam int ST_W      = 3;

    // Input pin positions
    localparam int PIN_PULSE = 0;
    localparam int PIN_HRST  = 1;
    localparam int PIN_GATE  = 2;
    localparam int PIN_N     = 3;

    // Counter and data registers
    localparam int COUNT_W = 16;
    localparam logic [15:0] COUNT_MAX = 16'hFFFF;
    localparam int DATA_DEPTH = 100;
    localparam int FAST_DEPTH = 32;
    localparam int DEST_W = 7;
    localparam logic [6:0] DEST_RESET = 7'h00;

    // Input filter
    localparam int FILT_W = 16;
    localparam logic [15:0] FILT_RESET = 16'h0003;

    // Timing: 10 kHz pulse rate leaves a 50 us half period
    localparam int CLK_PERIOD_NS = 5;
    localparam int MIN_HALF_NS   = 50000;
    localparam int HALF_CYC      = MIN_HALF_NS / CLK_PERIOD_NS;

endpackage

// *** input_filter.sv ***
`timescale 1ns/1ps
module input_filter
#(
    parameter int W = 16
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         nrst,
    // Pin and filter setting
    input  wire logic         pinIn,
    input  wire logic [W-1:0] filterLen,
    // Filtered level
    output logic              levelOut
);

    logic         meta_q;
    logic         sync_q;
    logic [W-1:0] stable_q;

    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= pinIn;
            sync_q <= meta_q;
        end
    end

    // A level must stay changed for filterLen + 1 cycles before it is taken
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            stable_q <= '0;
            levelOut <= 1'b0;
        end
        else if (sync_q == levelOut)
        begin
            stable_q <= '0;
        end
        else if (stable_q >= filterLen)
        begin
            stable_q <= '0;
            levelOut <= sync_q;
        end
        else
        begin
            stable_q <= stable_q + 1'b1;
        end
    end

endmodule

// *** data_reg_file.sv ***
`timescale 1ns/1ps
module data_reg_file
#(
    parameter int DEPTH = 100,
    parameter int W     = 16,
    parameter int AW    = 7
)
(
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // Software write port
    input  wire logic          swWr,
    input  wire logic [AW-1:0] swIdx,
    input  wire logic [W-1:0]  swData,
    // Counter transfer port
    input  wire logic          xferWr,
    input  wire logic [AW-1:0] xferIdx,
    input  wire logic [W-1:0]  xferData,
    // Read port
    input  wire logic [AW-1:0] rdIdx,
    output logic [W-1:0]       rdData
);

    logic [W-1:0] mem_q [DEPTH];

    // Transfer wins over a software write to the same word
    always_ff @(posedge clk_sys or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < DEPTH; i++)
            begin
                mem_q[i] <= '0;
            end
        end
        else
        begin
            if (swWr && (int'(swIdx) < DEPTH))
            begin
                mem_q[swIdx] <= swData;
            end
            if (xferWr && (int'(xferIdx) < DEPTH))
            begin
                mem_q[xferIdx] <= xferData;
            end
        end
    end

    assign rdData = (int'(rdIdx) < DEPTH) ? mem_q[rdIdx] : '0;

endmodule

// *** pin_source.sv ***
`timescale 1ns/1ps
module pin_source
#(
    parameter int HALF = 8
)
(
    // Clock
    input  wire logic clk_sys,
    // Pins toward the counter
    output logic      pulseInput,
    output logic      hardResetInput,
    output logic      gateInput
);
    initial
    begin
        pulseInput     = 1'b0;
        hardResetInput = 1'b0;
        gateInput      = 1'b0;
    end

    task automatic waitCyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // rate limit kept
    // Each level lasts HALF cycles, long enough for the default filter to pass it
    task automatic pulses(input int n, input logic onGate);
        repeat (n)
        begin
            @(posedge clk_sys);
            if (onGate)
                gateInput <= 1'b1;
            else
                pulseInput <= 1'b1;
            waitCyc(HALF);
            if (onGate)
                gateInput <= 1'b0;
            else
                pulseInput <= 1'b0;
            waitCyc(HALF - 1);
        end
        waitCyc(2 * HALF);
    endtask

    // Settle time covers sync flops, filter and the store on gate fall
    task automatic setPins(input logic g, input logic h, input logic p);
        @(posedge clk_sys);
        gateInput      <= g;
        hardResetInput <= h;
        pulseInput     <= p;
        waitCyc(2 * HALF);
    endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
    import gpc_pkg::*;
    logic        clk_sys     = 1'b0;
    logic        nrst        = 1'b0;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [11:0] paddr       = 12'h000;
    logic [31:0] pwdata      = 32'h00000000;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pulseInput;
    logic        hardResetInput;
    logic        gateInput;
    logic        irq;
    logic [31:0] rdVal;
    logic        rdErr;
    int          badCount    = 0;
    int          totalChecks = 0;
    int          dstTab[4]   = '{99, 100, 31, 32};

    always #2.5 clk_sys = ~clk_sys;

    // Fastest legal half period equals the pin model's level length
    gated_pulse_counter #(.HALF_PERIOD_CYC(8)) i_dut (
        .clk_sys        (clk_sys),
        .nrst           (nrst),
        .psel           (psel),
        .penable        (penable),
        .pwrite         (pwrite),
        .paddr          (paddr),
        .pwdata         (pwdata),
        .prdata         (prdata),
        .pready         (pready),
        .pslverr        (pslverr),
        .pulseInput     (pulseInput),
        .hardResetInput (hardResetInput),
        .gateInput      (gateInput),
        .irq            (irq)
    );

    pin_source #(.HALF(8)) i_src (
        .clk_sys        (clk_sys),
        .pulseInput     (pulseInput),
        .hardResetInput (hardResetInput),
        .gateInput      (gateInput)
    );

    task automatic tallyAndFinish();
        if (badCount == 0 && totalChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic chkVal(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkBit(input logic got, input logic exp);
        totalChecks++;
        if (got !== exp)
        begin
            badCount++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apbXfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
        begin
            badCount++;
            tallyAndFinish();
        end
        rdVal = prdata;
        rdErr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
        apbXfer(1'b0, a, 32'h00000000);
        chkVal(rdVal, exp);
    endtask

    function automatic logic [11:0] dataAddr(input int n);
        return OFF_DATA + 12'(4 * n);
    endfunction

    initial
    begin
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        rdChk(OFF_COUNT, 32'h00000000);
        rdChk(OFF_CTRL, 32'h00000000);
        rdChk(OFF_FILTER, 32'h00000003);
        chkBit(irq, 1'b0);
        apbXfer(1'b0, 12'h020, 32'h00000000);
        chkBit(rdErr, 1'b1);
        apbXfer(1'b1, dataAddr(5), 32'h0000A5C3);
        rdChk(dataAddr(5), 32'h0000A5C3);
        // Count is read only, software cannot preload it
        apbXfer(1'b1, OFF_COUNT, 32'h00001234);
        rdChk(OFF_COUNT, 32'h00000000);
        apbXfer(1'b1, OFF_CTRL, 32'h00000003);
        apbXfer(1'b1, OFF_DEST, 32'h00000014);
        apbXfer(1'b1, OFF_MASK, 32'h00000002);
        i_src.pulses(3, 1'b0);
        rdChk(OFF_COUNT, 32'h00000000);
        i_src.setPins(1'b1, 1'b0, 1'b0);
        i_src.pulses(5, 1'b0);
        rdChk(OFF_COUNT, 32'h00000005);
        i_src.setPins(1'b0, 1'b0, 1'b0);
        rdChk(dataAddr(20), 32'h00000005);
        rdChk(OFF_STATUS, 32'h00000002);
        chkBit(irq, 1'b1);
        apbXfer(1'b1, OFF_STATUS, 32'h00000002);
        // Status clears at the access edge; look once it has settled
        @(negedge clk_sys);
        chkBit(irq, 1'b0);
        i_src.setPins(1'b1, 1'b0, 1'b0);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000007);
        i_src.setPins(1'b0, 1'b0, 1'b1);
        i_src.pulses(3, 1'b1);
        rdChk(OFF_COUNT, 32'h0000000A);
        rdChk(dataAddr(20), 32'h0000000A);
        i_src.setPins(1'b1, 1'b0, 1'b0);
        apbXfer(1'b1, OFF_CTRL, 32'h00000002);
        i_src.pulses(4, 1'b0);
        rdChk(OFF_COUNT, 32'h0000000A);
        apbXfer(1'b1, OFF_CTRL, 32'h00000003);
        i_src.pulses(1, 1'b0);
        rdChk(OFF_COUNT, 32'h0000000B);
        i_src.setPins(1'b1, 1'b1, 1'b0);
        rdChk(OFF_COUNT, 32'h00000000);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000000);
        rdChk(OFF_INPUTS, 32'h00000006);
        apbXfer(1'b1, OFF_CTRL, 32'h00000001);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000002);
        apbXfer(1'b1, OFF_CTRL, 32'h00000005);
        rdChk(OFF_COUNT, 32'h00000000);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000000);
        // Destination bounds in both modes; error status is masked off the interrupt
        for (int i = 0; i < 4; i++)
        begin
            apbXfer(1'b1, OFF_CTRL, (i > 1) ? 32'h00000009 : 32'h00000001);
            apbXfer(1'b1, OFF_DEST, 32'(dstTab[i]));
            apbXfer(1'b1, OFF_STATUS, 32'h00000007);
            i_src.setPins(1'b1, 1'b0, 1'b0);
            i_src.pulses(1, 1'b0);
            i_src.setPins(1'b0, 1'b0, 1'b0);
            rdChk(OFF_STATUS, (i % 2 == 1) ? 32'h00000004 : 32'h00000002);
            chkBit(irq, (i % 2 == 0));
            if (dstTab[i] < 100)
                rdChk(dataAddr(dstTab[i]), (i % 2 == 1) ? 32'h0 : 32'(i + 1));
        end
        // Overflow needs 65536 pulses, too long here; the design's own checks cover it
        apbXfer(1'b1, OFF_FILTER, 32'h00000008);
        rdChk(OFF_FILTER, 32'h00000008);
        i_src.setPins(1'b1, 1'b0, 1'b0);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000006);
        // Longest filter setting is clamped so pulses at the top rate still count
        apbXfer(1'b1, OFF_FILTER, 32'h0000FFFF);
        rdChk(OFF_FILTER, 32'h0000FFFF);
        i_src.pulses(2, 1'b0);
        rdChk(OFF_COUNT, 32'h00000008);
        tallyAndFinish();
    end
endmodule
